// file: rtl/cfgcd_pkg.sv
// constants, command codes and carrier types of the configuration register decoder
// assumes a packet parser on the same clock delivers register addresses and words
package cfgcd_pkg;

  // clock timing
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // register addresses
  localparam logic [4:0] REG_CHECK = 5'h00;
  localparam logic [4:0] REG_FRAME_ADDR = 5'h01;
  localparam logic [4:0] REG_FRAME_IN = 5'h02;
  localparam logic [4:0] REG_FRAME_OUT = 5'h03;
  localparam logic [4:0] REG_COMMAND = 5'h04;
  localparam logic [4:0] REG_CONTROL0 = 5'h05;
  localparam logic [4:0] REG_WRITE_MASK = 5'h06;
  localparam logic [4:0] REG_STATUS = 5'h07;
  localparam logic [4:0] REG_CHAIN_OUT = 5'h08;
  localparam logic [4:0] REG_OPTION0 = 5'h09;
  localparam logic [4:0] REG_MULTI_WRITE = 5'h0A;
  localparam logic [4:0] REG_CIPHER_INIT = 5'h0B;
  localparam logic [4:0] REG_IDENTITY = 5'h0C;
  localparam logic [4:0] REG_USER_ACCESS = 5'h0D;
  localparam logic [4:0] REG_OPTION1 = 5'h0E;
  localparam logic [4:0] REG_WARM_START = 5'h10;
  localparam logic [4:0] REG_WATCHDOG = 5'h11;
  localparam logic [4:0] REG_BOOT_HISTORY = 5'h16;
  localparam logic [4:0] REG_CONTROL1 = 5'h18;
  localparam logic [4:0] REG_FLASH_OPT = 5'h1F;

  // commands
  typedef enum logic [4:0] {
    CMD_NULL = 5'h00, CMD_WRITE_FRAMES = 5'h01, CMD_MULTI_FRAME_WRITE = 5'h02,
    CMD_RELEASE_INTERCONNECT = 5'h03, CMD_READ_FRAMES = 5'h04, CMD_START = 5'h05,
    CMD_CLEAR_CAPTURE = 5'h06, CMD_RESET_CHECKSUM = 5'h07, CMD_HOLD_INTERCONNECT = 5'h08,
    CMD_SWITCH_CLOCK = 5'h09, CMD_RESTORE = 5'h0A, CMD_SHUTDOWN = 5'h0B,
    CMD_CAPTURE = 5'h0C, CMD_DESYNCHRONISE = 5'h0D, CMD_RESERVED = 5'h0E,
    CMD_WARM_BOOT = 5'h0F, CMD_RECALC_READBACK_CHECKSUM = 5'h10,
    CMD_RELOAD_WATCHDOG = 5'h11, CMD_FLASH_REREAD = 5'h12, CMD_FALL_EDGE = 5'h13
  } cfgcd_cmd_t;

  // frame geometry
  localparam int unsigned FRAME_BITS = 3232;
  localparam int unsigned WORD_BITS = 32;
  localparam logic [6:0] FRAME_LAST_WORD = 7'(FRAME_BITS / WORD_BITS - 1);

  // frame address fields
  localparam int unsigned FAR_TYPE_MSB = 25;
  localparam int unsigned FAR_TYPE_LSB = 23;
  localparam int unsigned FAR_HALF_BIT = 22;
  localparam int unsigned FAR_ROW_MSB = 21;
  localparam int unsigned FAR_ROW_LSB = 17;
  localparam int unsigned FAR_COL_MSB = 16;
  localparam int unsigned FAR_COL_LSB = 7;
  localparam int unsigned FAR_MINOR_MSB = 6;
  localparam int unsigned FAR_MINOR_LSB = 0;
  localparam logic [2:0] BLOCK_LOGIC = 3'h0;
  localparam logic [2:0] BLOCK_MEMORY = 3'h1;
  localparam logic [2:0] BLOCK_SPECIAL = 3'h2;

  // option word 0 frequency select field
  localparam int unsigned FSEL_LSB = 17;
  localparam int unsigned FSEL_W = 6;

  // status bit positions
  localparam int unsigned STAT_CHK_FAIL = 0;
  localparam int unsigned STAT_ALIGNED = 1;
  localparam int unsigned STAT_HOLD_N = 2;
  localparam int unsigned STAT_START_ARM = 3;
  localparam int unsigned STAT_SHUT_PEND = 4;
  localparam int unsigned STAT_CAPTURE = 5;
  localparam int unsigned STAT_FALL_EDGE = 6;
  localparam int unsigned STAT_MODE_LSB = 7;

  // checksum
  localparam logic [31:0] CHK_POLY = 32'h04C11DB7;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00, MODE_WRITE = 2'b01, MODE_MULTI = 2'b10, MODE_READ = 2'b11
  } cfgcd_mode_t;

  typedef enum logic [1:0] {
    REQ_WRITE = 2'b00, REQ_STAGE = 2'b01, REQ_COPY = 2'b10, REQ_READ = 2'b11
  } cfgcd_req_kind_t;

  typedef struct packed {
    logic valid;
    cfgcd_req_kind_t kind;
    logic [31:0] frame_addr;
    logic [6:0] word_idx;
    logic [31:0] data;
  } cfgcd_frame_req_t;

  typedef struct packed {
    logic restore;
    logic capture;
    logic recalc;
    logic start;
    logic shut;
    logic warm;
    logic wdog;
    logic flash;
    logic clk_switch;
  } cfgcd_pulses_t;

endpackage : cfgcd_pkg

// file: rtl/cfgcd_decoder.sv
// register set and command decoder of the configuration control logic
// assumes a packet parser on clk_i gives register strobes, and an external frame
// store answers readback_data_i for the word at frame_address_o / word_index_o
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1: matching check write clears failure, allows startup
// RULE2: frames are 101 words of 32 bits
// RULE3: frame address loads directly and auto-advances
// RULE4: block type in bits 25..23
// RULE5: bit 22 half, bits 21..17 row
// RULE6: bits 16..7 major column, left to right
// RULE7: bits 6..0 minor frame in column
// RULE8: input words go to current frame address
// RULE9: output register reads readback, read-only
// RULE10: frame address load re-executes held command
// RULE11: null command; write/read modes precede data
// RULE12: multi-frame write copies one frame around
// RULE13: hold and release interconnect commands
// RULE14: start arms; begins after check and cmd_desynchronise
// RULE15: capture pulse; clear capture command
// RULE16: reset checksum; recalc readback checksum
// RULE17: switch clock to option frequency select
// RULE18: restore command pulses global restore
// RULE19: shutdown waits for check match or reset
// RULE20: cmd_desynchronise clears alignment, pins then ignored
// RULE21: warm boot, watchdog reload, flash reread
// RULE22: switch data capture to falling edge
// RULE23: five-bit register address selects register
// RULE24: command in low five bits
// RULE25: reserved or undefined codes do nothing
// RULE26: bad-direction accesses have no side effect beyond writes still folding into the checksum
module cfgcd_decoder #(
  parameter logic [31:0] SYNC_WORD = 32'h5A5A_A5A5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port from packet parser
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // configuration pins
  input wire logic configuration_clock_i,
  input wire logic [31:0] cfg_data_i,
  output logic [31:0] link_word_o,
  output logic link_word_valid_o,
  output logic word_alignment_flag_o,
  // frame store
  output cfgcd_pkg::cfgcd_frame_req_t frame_req_o,
  output logic [31:0] frame_address_o,
  output logic [6:0] word_index_o,
  input wire logic [31:0] readback_data_i,
  input wire logic [31:0] boot_history_i,
  // global signals
  output logic interconnect_hold_n_o,
  output logic global_restore_pulse_o,
  output logic global_capture_pulse_o,
  output logic readback_crc_recalc_o,
  output logic startup_begin_o,
  output logic shutdown_begin_o,
  output logic warm_boot_o,
  output logic watchdog_reload_o,
  output logic flash_reread_o,
  output logic clock_switch_o,
  output logic [5:0] clock_frequency_select_o,
  output logic capture_fall_edge_o,
  output logic [31:0] control_word_0_o
);

  typedef struct packed {
    logic [31:0][31:0] regs;
    logic [31:0] chk;
    logic chk_fail;
    logic [31:0] frame_address;
    logic [4:0] cmd;
    cfgcd_pkg::cfgcd_mode_t mode;
    logic [6:0] widx;
    logic hold;
    logic capture_on;
    logic fall_edge;
    logic aligned;
    logic start_arm;
    logic chk_ok_seen;
    logic cmd_desynchronise_seen;
    logic shut_pend;
    cfgcd_pkg::cfgcd_pulses_t pulse;
    logic [5:0] fsel;
    logic [31:0] rdata;
    logic rvalid;
    cfgcd_pkg::cfgcd_frame_req_t req;
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic [31:0] dat_s1;
    logic [31:0] dat_s2;
    logic [31:0] link_word;
    logic link_valid;
  } cfgcd_state_t;

  cfgcd_state_t st_ff;
  cfgcd_state_t nxt_st;
  logic [31:0] far_inc_w;

  // serial checksum over one 32-bit word
  function automatic logic [31:0] chk_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      fb = r[31] ^ d[i];
      r = {r[30:0], 1'b0} ^ (fb ? cfgcd_pkg::CHK_POLY : 32'h0000_0000);
    end
    return r;
  endfunction : chk_step

  // next frame: minor, then column, then row
  function automatic logic [31:0] far_incr(input logic [31:0] f);
    logic [31:0] r;
    r = f;
    if (r[cfgcd_pkg::FAR_MINOR_MSB:cfgcd_pkg::FAR_MINOR_LSB] != '1) begin
      r[cfgcd_pkg::FAR_MINOR_MSB:cfgcd_pkg::FAR_MINOR_LSB] =
        r[cfgcd_pkg::FAR_MINOR_MSB:cfgcd_pkg::FAR_MINOR_LSB] + 7'h01; // RULE7
    end else begin
      r[cfgcd_pkg::FAR_MINOR_MSB:cfgcd_pkg::FAR_MINOR_LSB] = '0;
      if (r[cfgcd_pkg::FAR_COL_MSB:cfgcd_pkg::FAR_COL_LSB] != '1) begin
        r[cfgcd_pkg::FAR_COL_MSB:cfgcd_pkg::FAR_COL_LSB] =
          r[cfgcd_pkg::FAR_COL_MSB:cfgcd_pkg::FAR_COL_LSB] + 10'h001; // RULE6
      end else begin
        r[cfgcd_pkg::FAR_COL_MSB:cfgcd_pkg::FAR_COL_LSB] = '0;
        r[cfgcd_pkg::FAR_ROW_MSB:cfgcd_pkg::FAR_ROW_LSB] =
          r[cfgcd_pkg::FAR_ROW_MSB:cfgcd_pkg::FAR_ROW_LSB] + 5'h01; // RULE5
      end
    end
    return r;
  endfunction : far_incr

  // registers that software may read back
  function automatic logic is_readable(input logic [4:0] a);
    return !(a == cfgcd_pkg::REG_FRAME_IN || a == cfgcd_pkg::REG_CHAIN_OUT ||
             a == cfgcd_pkg::REG_MULTI_WRITE || a == cfgcd_pkg::REG_CIPHER_INIT);
  endfunction : is_readable

  // valid block types only reach the frame store
  function automatic logic type_ok(input logic [31:0] f);
    logic [2:0] t;
    t = f[cfgcd_pkg::FAR_TYPE_MSB:cfgcd_pkg::FAR_TYPE_LSB];
    return t == cfgcd_pkg::BLOCK_LOGIC || t == cfgcd_pkg::BLOCK_MEMORY ||
           t == cfgcd_pkg::BLOCK_SPECIAL; // RULE4
  endfunction : type_ok

  assign far_inc_w = far_incr(st_ff.frame_address);

  always_comb begin
    logic wr_cmd;
    logic wr_far;
    logic chk_match;
    logic do_reset_chk;
    logic [4:0] code;
    logic sel_edge;
    wr_cmd = reg_wr_i && reg_addr_i == cfgcd_pkg::REG_COMMAND; // RULE23
    wr_far = reg_wr_i && reg_addr_i == cfgcd_pkg::REG_FRAME_ADDR;
    chk_match = 1'b0;
    do_reset_chk = 1'b0;
    code = wr_cmd ? reg_wdata_i[4:0] : st_ff.cmd; // RULE24
    sel_edge = 1'b0;
    nxt_st = st_ff;
    nxt_st.pulse = '0;
    nxt_st.req.valid = 1'b0;
    nxt_st.rvalid = 1'b0;
    nxt_st.link_valid = 1'b0;

    // register writes
    if (reg_wr_i) begin
      if (reg_addr_i != cfgcd_pkg::REG_CHECK) begin
        nxt_st.chk = chk_step(st_ff.chk, reg_wdata_i);
      end
      unique case (reg_addr_i)
        cfgcd_pkg::REG_CHECK: begin
          chk_match = reg_wdata_i == st_ff.chk;
          nxt_st.chk_fail = !chk_match; // RULE1
        end
        cfgcd_pkg::REG_FRAME_ADDR: begin
          nxt_st.frame_address = reg_wdata_i; // RULE3
          nxt_st.widx = '0;
        end
        cfgcd_pkg::REG_COMMAND: nxt_st.cmd = reg_wdata_i[4:0];
        cfgcd_pkg::REG_CONTROL0, cfgcd_pkg::REG_CONTROL1: begin
          nxt_st.regs[reg_addr_i] =
            (st_ff.regs[reg_addr_i] & ~st_ff.regs[cfgcd_pkg::REG_WRITE_MASK])
            | (reg_wdata_i & st_ff.regs[cfgcd_pkg::REG_WRITE_MASK]);
        end
        cfgcd_pkg::REG_FRAME_IN: begin
          if (st_ff.mode == cfgcd_pkg::MODE_WRITE || st_ff.mode == cfgcd_pkg::MODE_MULTI) begin
            nxt_st.req.valid = type_ok(st_ff.frame_address);
            nxt_st.req.kind = st_ff.mode == cfgcd_pkg::MODE_WRITE ? cfgcd_pkg::REQ_WRITE
                                                                  : cfgcd_pkg::REQ_STAGE; // RULE8
            nxt_st.req.frame_addr = st_ff.frame_address;
            nxt_st.req.word_idx = st_ff.widx;
            nxt_st.req.data = reg_wdata_i;
            if (st_ff.widx == cfgcd_pkg::FRAME_LAST_WORD) begin
              nxt_st.widx = '0; // RULE2
              if (st_ff.mode == cfgcd_pkg::MODE_WRITE) begin
                nxt_st.frame_address = far_inc_w; // RULE3
              end
            end else begin
              nxt_st.widx = st_ff.widx + 7'h01;
            end
          end
        end
        cfgcd_pkg::REG_MULTI_WRITE: begin
          if (st_ff.mode == cfgcd_pkg::MODE_MULTI) begin
            nxt_st.req.valid = type_ok(st_ff.frame_address);
            nxt_st.req.kind = cfgcd_pkg::REQ_COPY; // RULE12
            nxt_st.req.frame_addr = st_ff.frame_address;
            nxt_st.req.word_idx = '0;
            nxt_st.req.data = reg_wdata_i;
          end
        end
        cfgcd_pkg::REG_FRAME_OUT, cfgcd_pkg::REG_STATUS, cfgcd_pkg::REG_BOOT_HISTORY: ; // RULE26
        default: nxt_st.regs[reg_addr_i] = reg_wdata_i;
      endcase
    end

    // register reads
    if (reg_rd_i) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = '0; // RULE26
      if (is_readable(reg_addr_i)) begin
        unique case (reg_addr_i)
          cfgcd_pkg::REG_CHECK: nxt_st.rdata = st_ff.chk;
          cfgcd_pkg::REG_FRAME_ADDR: nxt_st.rdata = st_ff.frame_address;
          cfgcd_pkg::REG_COMMAND: nxt_st.rdata = {27'h0000000, st_ff.cmd};
          cfgcd_pkg::REG_BOOT_HISTORY: nxt_st.rdata = boot_history_i;
          cfgcd_pkg::REG_STATUS: begin
            nxt_st.rdata[cfgcd_pkg::STAT_CHK_FAIL] = st_ff.chk_fail;
            nxt_st.rdata[cfgcd_pkg::STAT_ALIGNED] = st_ff.aligned;
            nxt_st.rdata[cfgcd_pkg::STAT_HOLD_N] = !st_ff.hold;
            nxt_st.rdata[cfgcd_pkg::STAT_START_ARM] = st_ff.start_arm;
            nxt_st.rdata[cfgcd_pkg::STAT_SHUT_PEND] = st_ff.shut_pend;
            nxt_st.rdata[cfgcd_pkg::STAT_CAPTURE] = st_ff.capture_on;
            nxt_st.rdata[cfgcd_pkg::STAT_FALL_EDGE] = st_ff.fall_edge;
            nxt_st.rdata[cfgcd_pkg::STAT_MODE_LSB +: 2] = st_ff.mode;
          end
          cfgcd_pkg::REG_FRAME_OUT: begin
            if (st_ff.mode == cfgcd_pkg::MODE_READ) begin
              nxt_st.rdata = readback_data_i; // RULE9
              nxt_st.req.valid = type_ok(st_ff.frame_address);
              nxt_st.req.kind = cfgcd_pkg::REQ_READ;
              nxt_st.req.frame_addr = st_ff.frame_address;
              nxt_st.req.word_idx = st_ff.widx;
              nxt_st.req.data = readback_data_i;
              if (st_ff.widx == cfgcd_pkg::FRAME_LAST_WORD) begin
                nxt_st.widx = '0; // RULE2
                nxt_st.frame_address = far_inc_w;
              end else begin
                nxt_st.widx = st_ff.widx + 7'h01;
              end
            end
          end
          default: nxt_st.rdata = st_ff.regs[reg_addr_i];
        endcase
      end
    end

    // command execution, also on every frame address load
    if (wr_cmd || wr_far) begin // RULE10
      case (code)
        cfgcd_pkg::CMD_WRITE_FRAMES: nxt_st.mode = cfgcd_pkg::MODE_WRITE; // RULE11
        cfgcd_pkg::CMD_MULTI_FRAME_WRITE: nxt_st.mode = cfgcd_pkg::MODE_MULTI; // RULE12
        cfgcd_pkg::CMD_READ_FRAMES: nxt_st.mode = cfgcd_pkg::MODE_READ; // RULE11
        cfgcd_pkg::CMD_RELEASE_INTERCONNECT: begin
          nxt_st.hold = 1'b0; // RULE13
          nxt_st.pulse.recalc = st_ff.hold; // RULE16
        end
        cfgcd_pkg::CMD_HOLD_INTERCONNECT: begin
          nxt_st.hold = 1'b1; // RULE13
          nxt_st.pulse.recalc = !st_ff.hold;
        end
        cfgcd_pkg::CMD_START: nxt_st.start_arm = 1'b1; // RULE14
        cfgcd_pkg::CMD_CLEAR_CAPTURE: nxt_st.capture_on = 1'b0; // RULE15
        cfgcd_pkg::CMD_CAPTURE: begin
          nxt_st.pulse.capture = 1'b1; // RULE15
          nxt_st.capture_on = 1'b1;
        end
        cfgcd_pkg::CMD_RESET_CHECKSUM: begin
          nxt_st.chk = '0; // RULE16
          nxt_st.chk_fail = 1'b0;
          do_reset_chk = 1'b1;
        end
        cfgcd_pkg::CMD_RECALC_READBACK_CHECKSUM: nxt_st.pulse.recalc = 1'b1; // RULE16
        cfgcd_pkg::CMD_SWITCH_CLOCK: begin
          nxt_st.pulse.clk_switch = 1'b1; // RULE17
          nxt_st.fsel =
            st_ff.regs[cfgcd_pkg::REG_OPTION0][cfgcd_pkg::FSEL_LSB +: cfgcd_pkg::FSEL_W];
        end
        cfgcd_pkg::CMD_RESTORE: nxt_st.pulse.restore = 1'b1; // RULE18
        cfgcd_pkg::CMD_SHUTDOWN: nxt_st.shut_pend = 1'b1; // RULE19
        cfgcd_pkg::CMD_DESYNCHRONISE: begin
          nxt_st.aligned = 1'b0; // RULE20
          nxt_st.cmd_desynchronise_seen = 1'b1;
        end
        cfgcd_pkg::CMD_WARM_BOOT: nxt_st.pulse.warm = 1'b1; // RULE21
        cfgcd_pkg::CMD_RELOAD_WATCHDOG: nxt_st.pulse.wdog = 1'b1; // RULE21
        cfgcd_pkg::CMD_FLASH_REREAD: nxt_st.pulse.flash = 1'b1; // RULE21
        cfgcd_pkg::CMD_FALL_EDGE: nxt_st.fall_edge = 1'b1; // RULE22
        default: ; // RULE25
      endcase
    end

    // startup and shutdown sequencing
    if (chk_match) begin
      nxt_st.chk_ok_seen = 1'b1; // RULE1
    end
    if (st_ff.shut_pend && (chk_match || do_reset_chk)) begin
      nxt_st.pulse.shut = 1'b1; // RULE19
      nxt_st.shut_pend = 1'b0;
    end
    if (nxt_st.start_arm && nxt_st.chk_ok_seen && nxt_st.cmd_desynchronise_seen && !nxt_st.chk_fail) begin
      nxt_st.pulse.start = 1'b1; // RULE14
      nxt_st.start_arm = 1'b0;
      nxt_st.chk_ok_seen = 1'b0;
      nxt_st.cmd_desynchronise_seen = 1'b0;
    end

    // pin sampling on the selected clock edge
    nxt_st.clk_s1 = configuration_clock_i;
    nxt_st.clk_s2 = st_ff.clk_s1;
    nxt_st.clk_s3 = st_ff.clk_s2;
    nxt_st.dat_s1 = cfg_data_i;
    nxt_st.dat_s2 = st_ff.dat_s1;
    sel_edge = st_ff.fall_edge ? (st_ff.clk_s3 && !st_ff.clk_s2)
                               : (!st_ff.clk_s3 && st_ff.clk_s2); // RULE22
    if (sel_edge) begin
      if (nxt_st.aligned) begin
        nxt_st.link_word = st_ff.dat_s2;
        nxt_st.link_valid = 1'b1;
      end else if (st_ff.dat_s2 == SYNC_WORD && !(wr_cmd || wr_far)) begin
        nxt_st.aligned = 1'b1; // RULE20
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o = st_ff.rdata;
  assign reg_rvalid_o = st_ff.rvalid;
  assign link_word_o = st_ff.link_word;
  assign link_word_valid_o = st_ff.link_valid;
  assign word_alignment_flag_o = st_ff.aligned;
  assign frame_req_o = st_ff.req;
  assign frame_address_o = st_ff.frame_address;
  assign word_index_o = st_ff.widx;
  assign interconnect_hold_n_o = !st_ff.hold;
  assign global_restore_pulse_o = st_ff.pulse.restore;
  assign global_capture_pulse_o = st_ff.pulse.capture;
  assign readback_crc_recalc_o = st_ff.pulse.recalc;
  assign startup_begin_o = st_ff.pulse.start;
  assign shutdown_begin_o = st_ff.pulse.shut;
  assign warm_boot_o = st_ff.pulse.warm;
  assign watchdog_reload_o = st_ff.pulse.wdog;
  assign flash_reread_o = st_ff.pulse.flash;
  assign clock_switch_o = st_ff.pulse.clk_switch;
  assign clock_frequency_select_o = st_ff.fsel;
  assign capture_fall_edge_o = st_ff.fall_edge;
  assign control_word_0_o = st_ff.regs[cfgcd_pkg::REG_CONTROL0];

  // checks
  chk_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE1
    reg_wr_i && reg_addr_i == cfgcd_pkg::REG_CHECK && reg_wdata_i == st_ff.chk
    |=> !st_ff.chk_fail && st_ff.chk_ok_seen || startup_begin_o)
    else $error("check match did not clear failure");
  frame_bound_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE2
    word_index_o <= cfgcd_pkg::FRAME_LAST_WORD)
    else $error("word index beyond frame");
  frame_advance_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE3
    reg_wr_i && reg_addr_i == cfgcd_pkg::REG_FRAME_IN && st_ff.mode == cfgcd_pkg::MODE_WRITE
    && word_index_o == cfgcd_pkg::FRAME_LAST_WORD
    |=> word_index_o == 7'h00 && frame_address_o == $past(far_inc_w))
    else $error("frame address did not advance");
  hold_on_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE13
    reg_wr_i && reg_addr_i == cfgcd_pkg::REG_COMMAND
    && reg_wdata_i[4:0] == cfgcd_pkg::CMD_HOLD_INTERCONNECT
    |=> !interconnect_hold_n_o ##1 (!interconnect_hold_n_o || $past(reg_wr_i)))
    else $error("interconnect hold not asserted");
  cmd_refire_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE10
    reg_wr_i && reg_addr_i == cfgcd_pkg::REG_FRAME_ADDR && st_ff.cmd == cfgcd_pkg::CMD_RESTORE
    |=> global_restore_pulse_o ##1 (!global_restore_pulse_o || $past(reg_wr_i)))
    else $error("command not re-executed on frame address load");
  start_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE14
    startup_begin_o |-> $past(st_ff.start_arm || reg_wr_i))
    else $error("startup without arming");
  cmd_desynchronise_quiet_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE20
    link_word_valid_o |-> word_alignment_flag_o)
    else $error("pin data passed while desynchronised");
  reserved_null_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE25
    reg_wr_i && reg_addr_i == cfgcd_pkg::REG_COMMAND
    && (reg_wdata_i[4:0] == cfgcd_pkg::CMD_RESERVED || reg_wdata_i[4:0] > cfgcd_pkg::CMD_FALL_EDGE)
    |=> $stable(interconnect_hold_n_o) && $stable(st_ff.mode) && !global_restore_pulse_o)
    else $error("undefined command changed state");
  ro_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE26
    reg_wr_i && reg_addr_i == cfgcd_pkg::REG_STATUS
    |=> $stable(frame_address_o) && $stable(st_ff.mode))
    else $error("write to status changed state");
  fsel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE17
    reg_wr_i && reg_addr_i == cfgcd_pkg::REG_COMMAND
    && reg_wdata_i[4:0] == cfgcd_pkg::CMD_SWITCH_CLOCK
    |=> clock_switch_o && clock_frequency_select_o ==
        $past(st_ff.regs[cfgcd_pkg::REG_OPTION0][cfgcd_pkg::FSEL_LSB +: cfgcd_pkg::FSEL_W]))
    else $error("clock switch wrong");
  startup_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) startup_begin_o);
  shutdown_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) shutdown_begin_o);
  frame_wrap_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    frame_req_o.valid && frame_req_o.word_idx == cfgcd_pkg::FRAME_LAST_WORD);

endmodule : cfgcd_decoder

`default_nettype wire

// file: test/cfgcd_host_model.sv
// host side: configuration pins and frame store answering readback
// assumes the bench raises run_i only during a link burst
`timescale 1ns/1ps
`default_nettype none
module cfgcd_host_model (
  // burst control and frame address
  input wire logic run_i,
  input wire logic [31:0] frame_address_i,
  // pins and store
  output logic configuration_clock_o,
  output logic [31:0] cfg_data_o,
  output logic [31:0] readback_data_o
);
  initial configuration_clock_o = 1'b0;
  // link clock still outside bursts
  always #24 if (run_i) configuration_clock_o = ~configuration_clock_o;
  assign cfg_data_o = run_i ? 32'h5A5AA5A5 : 32'hA5A55A5A;
  assign readback_data_o = frame_address_i;
endmodule : cfgcd_host_model
`default_nettype wire

// file: test/test_config_register_command_decoder.sv
// bench for the configuration register decoder, register port tasks
// assumes the host model in the same folder
`timescale 1ns/1ps
`default_nettype none
module test_config_register_command_decoder;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [4:0] reg_addr_i = 5'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic run = 1'b0;
  logic configuration_clock, hold_n, restore, aligned, rvalid;
  logic [31:0] pins, rb, rdata, fa;
  cfgcd_pkg::cfgcd_frame_req_t req;
  logic start, shut, warm, capture;
  logic [5:0] fsel;
  logic [31:0] lword;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  always #2.5 clk_i = ~clk_i;
  cfgcd_decoder uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .configuration_clock_i(configuration_clock),
    .cfg_data_i(pins), .link_word_o(lword), .link_word_valid_o(),
    .word_alignment_flag_o(aligned),
    .frame_req_o(req), .frame_address_o(fa), .word_index_o(), .readback_data_i(rb),
    .boot_history_i(32'h0), .interconnect_hold_n_o(hold_n), .global_restore_pulse_o(restore),
    .global_capture_pulse_o(capture), .readback_crc_recalc_o(), .startup_begin_o(start),
    .shutdown_begin_o(shut), .warm_boot_o(warm), .watchdog_reload_o(), .flash_reread_o(),
    .clock_switch_o(), .clock_frequency_select_o(fsel), .capture_fall_edge_o(),
    .control_word_0_o());
  cfgcd_host_model host (.run_i(run), .frame_address_i(fa), .configuration_clock_o(configuration_clock),
    .cfg_data_o(pins), .readback_data_o(rb));
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [4:0] a, logic [31:0] d);
    @(posedge clk_i);
    #1 reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge clk_i);
    #1 reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(logic [4:0] a);
    @(posedge clk_i);
    #1 reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(posedge clk_i);
    #1 reg_rd_i = 1'b0;
  endtask : rd
  task automatic conclude();
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    chk("hold_n", hold_n, 32'h1);
    wr(cfgcd_pkg::REG_COMMAND, 32'h8);
    chk("hold_n", hold_n, 32'h0);
    wr(cfgcd_pkg::REG_COMMAND, 32'hFFFFFFE3);
    chk("hold_n", hold_n, 32'h1);
    wr(cfgcd_pkg::REG_COMMAND, 32'hA);
    chk("restore", restore, 32'h1);
    wr(cfgcd_pkg::REG_FRAME_ADDR, 32'h00800085);
    chk("restore", restore, 32'h1);
    chk("far", fa, 32'h00800085);
    wr(cfgcd_pkg::REG_COMMAND, 32'hE);
    chk("restore", restore, 32'h0);
    chk("hold_n", hold_n, 32'h1);
    rd(cfgcd_pkg::REG_FRAME_ADDR);
    chk("rdata", rdata, 32'h00800085);
    rd(cfgcd_pkg::REG_FRAME_IN);
    chk("rdata", rdata, 32'h0);
    wr(cfgcd_pkg::REG_COMMAND, 32'h1);
    wr(cfgcd_pkg::REG_FRAME_ADDR, 32'h00800085);
    for (int i = 0; i < 101; i++) begin
      wr(cfgcd_pkg::REG_FRAME_IN, 32'hC0DE0000 + 32'(i));
      if (i == 0) begin
        chk("req_ctl", {req.valid, req.kind, req.word_idx}, {1'b1, 2'b00, 7'h00});
        chk("req_addr", req.frame_addr, 32'h00800085);
        chk("req_data", req.data, 32'hC0DE0000);
      end
    end
    chk("far", fa, 32'h00800086);
    wr(cfgcd_pkg::REG_COMMAND, 32'h4);
    wr(cfgcd_pkg::REG_FRAME_ADDR, 32'h00400000);
    rd(cfgcd_pkg::REG_FRAME_OUT);
    chk("rvalid", rvalid, 32'h1);
    chk("rdata", rdata, 32'h00400000);
    run = 1'b1;
    repeat (200) @(posedge clk_i);
    #1 run = 1'b0;
    chk("aligned", aligned, 32'h1);
    chk("link_word", lword, 32'h5A5AA5A5);
    wr(cfgcd_pkg::REG_COMMAND, 32'hD);
    chk("aligned", aligned, 32'h0);
    wr(cfgcd_pkg::REG_OPTION0, 32'h000A0000);
    wr(cfgcd_pkg::REG_COMMAND, 32'h9);
    chk("fsel", fsel, 32'h5);
    wr(cfgcd_pkg::REG_COMMAND, 32'hF);
    chk("warm", warm, 32'h1);
    wr(cfgcd_pkg::REG_COMMAND, 32'hC);
    chk("capture", capture, 32'h1);
    wr(cfgcd_pkg::REG_STATUS, 32'hFFFFFFFF);
    chk("far", fa, 32'h00400000);
    wr(cfgcd_pkg::REG_COMMAND, 32'h5);
    wr(cfgcd_pkg::REG_COMMAND, 32'hB);
    chk("shut", shut, 32'h0);
    wr(cfgcd_pkg::REG_COMMAND, 32'h7);
    chk("shut", shut, 32'h1);
    chk("start", start, 32'h0);
    rd(cfgcd_pkg::REG_CHECK);
    chk("rdata", rdata, 32'h0);
    wr(cfgcd_pkg::REG_CHECK, 32'h0);
    chk("start", start, 32'h1);
    conclude();
  end
endmodule : test_config_register_command_decoder
`default_nettype wire
